// >>> core/address_breakpoint_unit.sv
// Address breakpoint unit: match logic, break state, register slave
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps

// Summary of operation
// - Address equal to break address while enabled raises breakpoint request.
// - CPU finishes instruction, loads software interrupt, vectors user or monitor page.
// - Break triggered by program address match or software writing active bit.
// - Return-from-interrupt inside break routine ends break state.
// - Break on opcode address: instruction also completes before break.
// - Break on operand address: instruction completes before break.
// - Software request taken just before next instruction starts.
// - Active bit cleared, address unchanged: no further break after return.
// - New address plus cleared active bit allows repeated breaks.
// - Timer counter halted while break active.
// - Watchdog disabled in break when high test voltage on reset pin.
// - Flag-clear-enable bit decides if flags clearable in break.
// - Match enable bit 7, read/write, resets to zero.
// - Active bit set by match, write one requests, write zero clears.
// - High and low break address bytes, cleared by reset.
// - Works in wait mode; wait-exit flag records break exit from wait.
// - Inactive in stop mode; registers keep their contents.
// - Peripheral registers stay accessible during break service.
// - Monitor mode takes vectors from the FE page.
module address_breakpoint_unit (
  // Clock, reset, enable
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic CLK_EN_I,
  // Avalon-MM slave
  input wire logic [15:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [7:0] AVS_WRITEDATA_I,
  output logic [7:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // CPU side
  input wire brk_pkg::cpu_bus_t CPU_BUS_I,
  input wire logic MONITOR_MODE_I,
  input wire logic WAIT_MODE_I,
  input wire logic STOP_MODE_I,
  input wire logic HIGH_TEST_VOLTAGE_I,
  // System integration side
  output brk_pkg::sim_req_t SIM_REQ_O,
  output logic BREAK_ACTIVE_O,
  output logic TIMER_HALT_O,
  output logic WATCHDOG_DISABLE_O,
  output logic FLAG_CLEAR_ALLOWED_O,
  output logic PERIPH_ACCESS_OK_O
);
  import brk_pkg::*;

  logic [7:0] addr_high_q;
  logic [7:0] addr_low_q;
  logic match_en_q;
  logic active_flag_q;
  logic flag_clr_en_q;
  logic wait_exit_q;
  logic ack_q;
  logic [7:0] rdata_q;
  logic [15:0] last_hit_q;
  logic rearm_q;
  brk_state_t state_q;
  brk_state_t state_d;
  logic run;
  logic acc;
  logic wr_hit;
  logic addr_match;
  logic sw_request;
  logic take_break;
  logic rti_seen;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // Stop mode freezes the unit; registers keep state
  assign run = CLK_EN_I && !STOP_MODE_I;
  assign acc = (AVS_READ_I || AVS_WRITE_I) && !ack_q;
  assign wr_hit = AVS_WRITE_I && !ack_q && run;

  // One wait cycle per access, then ack
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      ack_q <= 1'b0;
    end else if (run) begin
      ack_q <= acc;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
    end else if (run) begin
      AVS_WAITREQUEST_O <= !acc;
    end
  end

  // Registers stay readable even while a break is being serviced
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      rdata_q <= RST_BYTE;
    end else if (run && AVS_READ_I && !ack_q) begin
      if (hit(AVS_ADDRESS_I, OFS_ADDR_HIGH)) begin
        rdata_q <= addr_high_q;
      end else if (hit(AVS_ADDRESS_I, OFS_ADDR_LOW)) begin
        rdata_q <= addr_low_q;
      end else if (hit(AVS_ADDRESS_I, OFS_CTRL_STATUS)) begin
        rdata_q <= {match_en_q, active_flag_q, 6'h00};
      end else if (hit(AVS_ADDRESS_I, OFS_BREAK_FLAG_CTRL)) begin
        rdata_q <= {flag_clr_en_q, 7'h00};
      end else if (hit(AVS_ADDRESS_I, OFS_WAIT_STATUS)) begin
        rdata_q <= {6'h00, wait_exit_q, 1'b0};
      end else begin
        rdata_q <= RST_BYTE;
      end
    end
  end
  assign AVS_READDATA_O = rdata_q;

  // ----------------------------------------------------------------
  // Address and control registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      addr_high_q <= RST_BYTE;
      addr_low_q <= RST_BYTE;
    end else if (wr_hit) begin
      if (hit(AVS_ADDRESS_I, OFS_ADDR_HIGH)) begin
        addr_high_q <= AVS_WRITEDATA_I;
      end
      if (hit(AVS_ADDRESS_I, OFS_ADDR_LOW)) begin
        addr_low_q <= AVS_WRITEDATA_I;
      end
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      match_en_q <= 1'b0;
    end else if (wr_hit && hit(AVS_ADDRESS_I, OFS_CTRL_STATUS)) begin
      match_en_q <= AVS_WRITEDATA_I[BIT_MATCH_EN];
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      flag_clr_en_q <= 1'b0;
    end else if (wr_hit && hit(AVS_ADDRESS_I, OFS_BREAK_FLAG_CTRL)) begin
      flag_clr_en_q <= AVS_WRITEDATA_I[BIT_FLAG_CLR_EN];
    end
  end

  // ----------------------------------------------------------------
  // Match detection
  // ----------------------------------------------------------------
  // Only program fetches compare; data cycles cannot trigger
  assign addr_match = run && match_en_q && CPU_BUS_I.fetch &&
    (CPU_BUS_I.addr == {addr_high_q, addr_low_q});
  assign sw_request = wr_hit && hit(AVS_ADDRESS_I, OFS_CTRL_STATUS) &&
    AVS_WRITEDATA_I[BIT_ACTIVE];
  assign rti_seen = run && (state_q == ST_ACTIVE) && CPU_BUS_I.opcode_fetch &&
    (CPU_BUS_I.opcode == RTI_OPCODE);

  // An address that already broke once stays quiet until the break
  // address registers change; this is what lets a cleared
  // flag with an unchanged address suppress a second break.
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      last_hit_q <= 16'h0000;
      rearm_q <= 1'b1;
    end else if (run) begin
      if (addr_match && rearm_q && state_q == ST_IDLE) begin
        last_hit_q <= CPU_BUS_I.addr;
        rearm_q <= 1'b0;
      end else if ({addr_high_q, addr_low_q} != last_hit_q) begin
        rearm_q <= 1'b1;
      end
    end
  end

  // Set by match or software write; set wins over a same-cycle clear
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      active_flag_q <= 1'b0;
    end else if (run) begin
      if ((addr_match && rearm_q) || sw_request) begin
        active_flag_q <= 1'b1;
      end else if (wr_hit && hit(AVS_ADDRESS_I, OFS_CTRL_STATUS)) begin
        active_flag_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Break sequencing
  // ----------------------------------------------------------------
  // Pending break waits for the instruction boundary: opcode hits
  // and operand hits alike break after that instruction.
  assign take_break = (state_q == ST_PENDING) && CPU_BUS_I.instr_boundary;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if ((addr_match && rearm_q) || sw_request) begin
          state_d = ST_PENDING;
        end
      end
      ST_PENDING: begin
        if (take_break) begin
          state_d = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (rti_seen) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      state_q <= ST_IDLE;
    end else if (run) begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      wait_exit_q <= 1'b0;
    end else if (run) begin
      if (take_break && WAIT_MODE_I) begin
        wait_exit_q <= 1'b1;
      end else if (wr_hit && hit(AVS_ADDRESS_I, OFS_WAIT_STATUS)) begin
        wait_exit_q <= AVS_WRITEDATA_I[BIT_WAIT_EXIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs to system integration logic
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      SIM_REQ_O <= '0;
      BREAK_ACTIVE_O <= 1'b0;
      TIMER_HALT_O <= 1'b0;
      WATCHDOG_DISABLE_O <= 1'b0;
      FLAG_CLEAR_ALLOWED_O <= 1'b1;
      PERIPH_ACCESS_OK_O <= 1'b1;
    end else if (run) begin
      SIM_REQ_O.breakpoint_request <= (state_d == ST_PENDING);
      SIM_REQ_O.load_swi <= take_break;
      SIM_REQ_O.swi_opcode <= SWI_OPCODE;
      SIM_REQ_O.vector <= MONITOR_MODE_I ? VEC_MONITOR : VEC_USER;
      BREAK_ACTIVE_O <= (state_d == ST_ACTIVE);
      TIMER_HALT_O <= (state_d == ST_ACTIVE);
      WATCHDOG_DISABLE_O <= (state_d == ST_ACTIVE) && HIGH_TEST_VOLTAGE_I;
      FLAG_CLEAR_ALLOWED_O <= (state_d != ST_ACTIVE) || flag_clr_en_q;
      PERIPH_ACCESS_OK_O <= 1'b1;
    end
  end
endmodule // address_breakpoint_unit

// >>> shared/brk_pkg.sv
// Package for the address breakpoint unit: register map, fields, vectors, types
package brk_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam logic [15:0] OFS_ADDR_HIGH = 16'hFE0C;
  localparam logic [15:0] OFS_ADDR_LOW = 16'hFE0D;
  localparam logic [15:0] OFS_CTRL_STATUS = 16'hFE0E;
  localparam logic [15:0] OFS_BREAK_FLAG_CTRL = 16'hFE10;
  localparam logic [15:0] OFS_WAIT_STATUS = 16'hFE11;
  localparam int unsigned BIT_MATCH_EN = 7;
  localparam int unsigned BIT_ACTIVE = 6;
  localparam int unsigned BIT_FLAG_CLR_EN = 7;
  localparam int unsigned BIT_WAIT_EXIT = 1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] CTRL_RW_MASK = 8'hC0;
  localparam logic [15:0] VEC_USER = 16'hFFFC;
  localparam logic [15:0] VEC_MONITOR = 16'hFEFC;
  localparam logic [7:0] SWI_OPCODE = 8'h83;
  localparam logic [7:0] RTI_OPCODE = 8'h80;

  typedef struct packed {
    logic [15:0] addr;
    logic fetch;
    logic opcode_fetch;
    logic instr_boundary;
    logic [7:0] opcode;
  } cpu_bus_t;

  typedef struct packed {
    logic breakpoint_request;
    logic load_swi;
    logic [7:0] swi_opcode;
    logic [15:0] vector;
  } sim_req_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PENDING,
    ST_ACTIVE
  } brk_state_t;
endpackage

// >>> test/brk_chk_sva.sv
// Port checker for the address breakpoint unit
`timescale 1ns/1ps
module brk_chk (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic CLK_EN_I,
  // Register bus
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic AVS_WAITREQUEST_O,
  // Break side
  input wire logic MONITOR_MODE_I,
  input wire brk_pkg::sim_req_t SIM_REQ_O,
  input wire logic BREAK_ACTIVE_O,
  input wire logic TIMER_HALT_O,
  input wire logic WATCHDOG_DISABLE_O,
  input wire logic PERIPH_ACCESS_OK_O
);
  import brk_pkg::*;
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_take;
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O && CLK_EN_I;
  endsequence
  sequence s_swi;
    SIM_REQ_O.load_swi;
  endsequence
  AST_ACK: assert property (s_take |-> ##[1:2] !AVS_WAITREQUEST_O)
    else $error("bus request not answered");
  AST_ACK_ONE: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("answer held too long");
  // Vector is registered on the same edge as the pulse, from the mode one edge earlier; the request is high the cycle before
  AST_VEC: assert property (s_swi |-> SIM_REQ_O.vector == ($past(MONITOR_MODE_I) ? VEC_MONITOR : VEC_USER))
    else $error("wrong vector");
  AST_OPC: assert property (s_swi |-> SIM_REQ_O.swi_opcode == SWI_OPCODE && $past(SIM_REQ_O.breakpoint_request))
    else $error("wrong forced opcode");
  AST_PULSE: assert property (s_swi |=> !SIM_REQ_O.load_swi)
    else $error("forced load longer than one cycle");
  AST_ACT: assert property (s_swi |-> ##[0:1] BREAK_ACTIVE_O)
    else $error("break state not entered");
  AST_TMR: assert property (TIMER_HALT_O == BREAK_ACTIVE_O)
    else $error("timer halt differs from break state");
  AST_WDG: assert property (WATCHDOG_DISABLE_O |-> BREAK_ACTIVE_O)
    else $error("watchdog off outside break");
  AST_PER: assert property (PERIPH_ACCESS_OK_O)
    else $error("peripheral access blocked");
endmodule // brk_chk
bind address_breakpoint_unit brk_chk brk_chk_inst (.*);

// >>> test/cpu_model.sv
// CPU core model: fetch stream, break entry and return
`timescale 1ns/1ps
module cpu_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire brk_pkg::sim_req_t req_i,
  input wire logic rti_i,
  output brk_pkg::cpu_bus_t bus_o
);
  import brk_pkg::*;
  logic [1:0] ph_q;
  logic [15:0] pc_q;
  logic brk_q;
  // Program loops over 0x0100..0x010E, two bytes per instruction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_q <= 2'h0;
      pc_q <= 16'h0100;
      brk_q <= 1'b0;
    end else if (req_i.load_swi) begin
      brk_q <= 1'b1;
    end else if (brk_q) begin
      if (rti_i) brk_q <= 1'b0;
    end else begin
      ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
      if (ph_q == 2'h2) pc_q <= {pc_q[15:4], pc_q[3:0] + 4'h2};
    end
  end
  // Break shows 0xF000, otherwise pc plus phase; the inverse-address default is always overridden
  always_comb begin
    bus_o = '0;
    bus_o.addr = ~pc_q;
    if (brk_q) begin
      bus_o.fetch = rti_i;
      bus_o.opcode_fetch = rti_i;
      bus_o.opcode = RTI_OPCODE;
      bus_o.addr = 16'hF000;
    end else begin
      bus_o.fetch = ph_q != 2'h2;
      bus_o.opcode_fetch = ph_q == 2'h0;
      bus_o.addr = pc_q + {14'h0, ph_q};
      bus_o.instr_boundary = ph_q == 2'h2;
      bus_o.opcode = 8'h9D;
    end
  end
endmodule // cpu_model

// >>> test/tb.sv
// Register and break scenarios for the address breakpoint unit
`timescale 1ns/1ps
module tb;
  import brk_pkg::*;
  logic clk = 0, rst = 1, en = 1, rd = 0, wr = 0, mon = 0, wt = 0, stp = 0, htv = 0, interrupt_return_opcode = 0;
  logic [15:0] addr = 16'h0;
  logic [7:0] wd = 8'h0, rdata, q;
  logic wrq, act, thalt, wdg, fca, pok;
  cpu_bus_t bus;
  sim_req_t req;
  int bad_count = 0, total_checks = 0;
  always #2 clk = ~clk;
  address_breakpoint_unit address_breakpoint_unit_inst (.REF_CLK_I(clk), .RST_I(rst), .CLK_EN_I(en),
    .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wrq), .CPU_BUS_I(bus), .MONITOR_MODE_I(mon),
    .WAIT_MODE_I(wt), .STOP_MODE_I(stp), .HIGH_TEST_VOLTAGE_I(htv), .SIM_REQ_O(req),
    .BREAK_ACTIVE_O(act), .TIMER_HALT_O(thalt), .WATCHDOG_DISABLE_O(wdg),
    .FLAG_CLEAR_ALLOWED_O(fca), .PERIPH_ACCESS_OK_O(pok));
  cpu_model cpu_model_inst (.clk_i(clk), .rst_i(rst), .req_i(req), .rti_i(interrupt_return_opcode), .bus_o(bus));
  // ----
  // Tasks
  // ----
  task automatic end_of_test();
    if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic fail(input logic [7:0] got, input logic [7:0] exp);
    bad_count++;
    $display("[ERR] %0t got %h expected %h", $time, got, exp);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) fail(got, exp);
  endtask
  // Idle edge first so a strobe is never set twice in one step
  task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] d);
    int n;
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wrq !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) begin
      fail(wrq, 8'h0);
      end_of_test();
    end
  endtask
  task automatic wrc(input logic [15:0] a, input logic [7:0] d);
    acc(a, 1'b1, d);
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    acc(a, 1'b0, 8'h0);
    chk(q, exp);
  endtask
  task automatic wait_act(input logic v);
    int n;
    n = 0;
    while (act !== v && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n >= 100) begin
      fail(act, v);
      end_of_test();
    end
  endtask
  task automatic leave_break();
    interrupt_return_opcode <= 1'b1;
    wait_act(1'b0);
    interrupt_return_opcode <= 1'b0;
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdc(OFS_ADDR_HIGH, 8'h00);
    rdc(OFS_ADDR_LOW, 8'h00);
    rdc(OFS_CTRL_STATUS, 8'h00);
    rdc(16'hFE12, 8'h00);
    wrc(OFS_CTRL_STATUS, 8'hBF);
    rdc(OFS_CTRL_STATUS, 8'h80);
    wrc(OFS_CTRL_STATUS, 8'h00);
    rdc(OFS_CTRL_STATUS, 8'h00);
    wrc(OFS_ADDR_HIGH, 8'h01);
    wrc(OFS_ADDR_LOW, 8'h04);
    rdc(OFS_ADDR_HIGH, 8'h01);
    rdc(OFS_ADDR_LOW, 8'h04);
    htv <= 1'b1;
    wrc(OFS_CTRL_STATUS, 8'h80);
    wait_act(1'b1);
    rdc(OFS_CTRL_STATUS, 8'hC0);
    chk({7'h0, thalt}, 8'h01);
    chk({7'h0, wdg}, 8'h01);
    chk({7'h0, fca}, 8'h00);
    wrc(OFS_BREAK_FLAG_CTRL, 8'h80);
    repeat (2) @(posedge clk);
    chk({7'h0, fca}, 8'h01);
    wrc(OFS_BREAK_FLAG_CTRL, 8'h00);
    wrc(OFS_CTRL_STATUS, 8'h80);
    leave_break();
    repeat (60) @(posedge clk);
    chk({7'h0, act}, 8'h00);
    wrc(OFS_ADDR_LOW, 8'h07);
    wait_act(1'b1);
    wrc(OFS_CTRL_STATUS, 8'h00);
    leave_break();
    mon <= 1'b1;
    wt <= 1'b1;
    wrc(OFS_CTRL_STATUS, 8'h40);
    wait_act(1'b1);
    rdc(OFS_WAIT_STATUS, 8'h02);
    wt <= 1'b0;
    wrc(OFS_CTRL_STATUS, 8'h00);
    leave_break();
    stp <= 1'b1;
    repeat (5) @(posedge clk);
    stp <= 1'b0;
    rdc(OFS_ADDR_LOW, 8'h07);
    end_of_test();
  end
endmodule // tb
